/* i2cp_port.sv */
`timescale 1ns/1ps
`include "i2cp_map.svh"
// Overview of operation
// RULE1: master busy buffer write sets collision
// RULE2: slave write during shifting sets collision
// RULE3: byte into full buffer sets overflow
// RULE4: enable bit hands pins to port
// RULE5: slave clock held low while release zero
// RULE6: mode field selects slave/master variant
// RULE7: master clock is sysclk/(4*(reload+1))
// RULE8: general call accepted only when enabled
// RULE9: ack status shows slave nack
// RULE10: ack request sends programmed ack bit
// RULE11: receive request clocks in one byte
// RULE12: stop request makes stop, self clears
// RULE13: repeated start request, self clears
// RULE14: start request makes start, self clears
// RULE15: slave stretch bit extends stretch to receive
// RULE16: busy master refuses requests and writes
// RULE17: pins driven open drain only
// RULE18: slave flags address match, start, stop; start and stop are flagged only in the S7I and S10I modes
// RULE19: slave acks and buffers matched bytes
// RULE20: full buffer withholds ack, still flags
// RULE21: sample on rise, compare on eighth fall
// RULE22: match loads buffer, flags ninth fall
// RULE23: ten-bit address needs address update
// RULE24: received byte moves to buffer, flags
// RULE25: update flag shows address rewrite due
// RULE26: unlisted modes leave pins undriven
module i2cp_port (
  input wire logic sys_clk_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire i2cp_pkg::i2cp_req_t req_i, // Register access
  output logic [7:0] rdata_o, // Read data
  input wire logic scl_i, // Clock pin level
  input wire logic sda_i, // Data pin level
  input wire logic scl_dir_in_i, // Clock pin set as input
  input wire logic sda_dir_in_i, // Data pin set as input
  output logic scl_o, // Clock pin drive value
  output logic scl_oe_n_o, // Clock pin enable, low drives
  output logic sda_o, // Data pin drive value
  output logic sda_oe_n_o, // Data pin enable, low drives
  output logic port_flag_o // Port interrupt flag
);

  // ************************************************************
  // Registers and decode
  // ************************************************************
  logic write_collision_flag_r, ov_r, en_r, ckp_r;
  logic [3:0] mode_r;
  logic general_call_enable_r, ackst_r, ack_data_value_r, ack_sequence_request_r, master_receive_request_r, pen_r, repeated_start_request_r, sen_r;
  logic [7:0] buf_r, addr_r;
  logic bf_r, ua_r, rw_r, da_r, s_r, p_r;
  logic wr_c1, wr_c2, wr_buf, wr_addr, wr_flag, rd_buf;
  logic slv, ten, hwm, pins_ok, sl_on;
  logic scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det;

  assign wr_c1 = req_i.we & (req_i.addr == `I2CP_A_CTL1);
  assign wr_c2 = req_i.we & (req_i.addr == `I2CP_A_CTL2);
  assign wr_buf = req_i.we & (req_i.addr == `I2CP_A_BUF);
  assign wr_addr = req_i.we & (req_i.addr == `I2CP_A_ADDR);
  assign wr_flag = req_i.we & (req_i.addr == `I2CP_A_FLAG);
  assign rd_buf = req_i.re & (req_i.addr == `I2CP_A_BUF);

  // Mode decode; firmware master leaves the engine idle
  assign slv = (mode_r == `I2CP_M_S10I) | (mode_r == `I2CP_M_S7I) |
               (mode_r == `I2CP_M_S10) | (mode_r == `I2CP_M_S7); // RULE6
  assign ten = slv & mode_r[0]; // RULE6
  assign hwm = en_r & (mode_r == `I2CP_M_HWM); // RULE6
  assign sl_on = en_r & slv;
  assign pins_ok = (sl_on | hwm) & scl_dir_in_i & sda_dir_in_i; // RULE4 RULE17 RULE26

  // Bus edges; pins are synchronous so one stage suffices
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_det = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_det = scl_i & scl_q & ~sda_q & sda_i;

  // ************************************************************
  // Master sequencer
  // ************************************************************
  i2cp_pkg::i2cp_mst_t m_st_r;
  logic [1:0] q_r;
  logic [3:0] mb_r;
  logic [6:0] brg_r;
  logic [7:0] m_sr_r;
  logic m_scl_r, m_sda_r, tick, m_busy, m_last, m_done, m_ackev, m_rxld, m_bit_low;

  assign tick = (brg_r == 7'h00);
  assign m_busy = hwm & ((m_st_r != i2cp_pkg::M_IDLE) | sen_r | repeated_start_request_r | pen_r | master_receive_request_r | ack_sequence_request_r);
  assign m_last = (m_st_r == i2cp_pkg::M_TX) ? (mb_r == `I2CP_BITS) :
                  (m_st_r == i2cp_pkg::M_RX) ? (mb_r == `I2CP_BITS - 4'h1) : 1'h1;
  assign m_done = tick & (m_st_r != i2cp_pkg::M_IDLE) & (q_r == `I2CP_QLAST) & m_last;
  assign m_ackev = tick & (m_st_r == i2cp_pkg::M_TX) & (q_r == 2'h2) & (mb_r == `I2CP_BITS);
  assign m_rxld = m_done & (m_st_r == i2cp_pkg::M_RX);
  // Low data level for the current bit slot
  assign m_bit_low = (m_st_r == i2cp_pkg::M_TX) ? ((mb_r < `I2CP_BITS) & ~m_sr_r[7]) :
                     (m_st_r == i2cp_pkg::M_ACK) ? ~ack_data_value_r : 1'h0; // RULE10

  // Each quarter bit lasts reload+1 clocks, so a bit is four of them
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m_st_r <= i2cp_pkg::M_IDLE;
      q_r <= 2'h0;
      mb_r <= 4'h0;
      brg_r <= 7'h00;
      m_sr_r <= 8'h00;
      m_scl_r <= 1'h0;
      m_sda_r <= 1'h0;
    end else if (!hwm) begin
      m_st_r <= i2cp_pkg::M_IDLE;
      m_scl_r <= 1'h0;
      m_sda_r <= 1'h0;
    end else if (m_st_r == i2cp_pkg::M_IDLE) begin
      q_r <= 2'h0;
      mb_r <= 4'h0;
      brg_r <= addr_r[6:0]; // RULE7
      if (sen_r) begin
        m_st_r <= i2cp_pkg::M_START; // RULE14
      end else if (repeated_start_request_r) begin
        m_st_r <= i2cp_pkg::M_RSTART; // RULE13
      end else if (pen_r) begin
        m_st_r <= i2cp_pkg::M_STOP; // RULE12
      end else if (master_receive_request_r) begin
        m_st_r <= i2cp_pkg::M_RX; // RULE11
      end else if (ack_sequence_request_r) begin
        m_st_r <= i2cp_pkg::M_ACK; // RULE10
      end else if (wr_buf) begin
        m_sr_r <= req_i.wdata;
        m_st_r <= i2cp_pkg::M_TX;
      end
    end else begin
      brg_r <= tick ? addr_r[6:0] : brg_r - 7'h01; // RULE7
      if (tick) begin
        q_r <= q_r + 2'h1;
        case (m_st_r)
          i2cp_pkg::M_START: begin
            m_sda_r <= 1'h1; // RULE14
            m_scl_r <= (q_r != 2'h0);
          end
          i2cp_pkg::M_RSTART: begin
            m_sda_r <= q_r[1]; // RULE13
            m_scl_r <= (q_r[0] == q_r[1]);
          end
          i2cp_pkg::M_STOP: begin
            m_sda_r <= ~q_r[1]; // RULE12
            m_scl_r <= (q_r == 2'h0);
          end
          default: begin
            m_scl_r <= (q_r[0] == q_r[1]);
            if (q_r == 2'h0) begin
              m_sda_r <= m_bit_low;
            end
            if (q_r == 2'h2 && m_st_r == i2cp_pkg::M_RX) begin
              m_sr_r <= {m_sr_r[6:0], sda_i}; // RULE11
            end
            if (q_r == `I2CP_QLAST) begin
              mb_r <= mb_r + 4'h1;
              if (m_st_r == i2cp_pkg::M_TX) begin
                m_sr_r <= {m_sr_r[6:0], 1'h0};
              end
            end
          end
        endcase
        if (m_done) begin
          m_st_r <= i2cp_pkg::M_IDLE;
        end
      end
    end
  end

  // ************************************************************
  // Slave engine
  // ************************************************************
  logic sl_act_r, sl_aph_r, sl_adr_r, sl_tx_r, sl_txd_r, sl_ack_r, took_r, uap_r, tb_hi_r, tb_ok_r;
  logic [3:0] bcnt_r;
  logic [7:0] sl_sr_r;
  logic sl_byte, sl_ninth, gcall, hi_hit, hdr_rd, adr_hit, take, sl_ld, write_collision_flag_ev, ckp_clr;

  assign sl_byte = sl_on & sl_act_r & scl_fall & (bcnt_r == `I2CP_BITS); // RULE21
  assign sl_ninth = sl_on & sl_act_r & scl_fall & (bcnt_r == `I2CP_BITS + 4'h1);
  assign gcall = general_call_enable_r & (sl_sr_r == `I2CP_GCALL) & sl_aph_r & ~tb_hi_r; // RULE8
  assign hi_hit = (sl_sr_r[7:1] == addr_r[7:1]); // RULE21
  assign hdr_rd = ten & sl_sr_r[0] & (sl_sr_r[7:3] == `I2CP_TENHDR);

  // Address match for the byte now in the shift register
  always_comb begin
    adr_hit = 1'h0;
    if (gcall) begin
      adr_hit = 1'h1; // RULE8
    end else if (!ten) begin
      adr_hit = hi_hit;
    end else if (tb_hi_r) begin
      adr_hit = (sl_sr_r == addr_r); // RULE23
    end else begin
      adr_hit = (sl_sr_r[7:3] == `I2CP_TENHDR) & hi_hit & (~sl_sr_r[0] | tb_ok_r); // RULE23
    end
  end
  assign take = sl_byte & (sl_aph_r ? adr_hit : (sl_adr_r & ~sl_tx_r));
  assign sl_ld = take & ~bf_r & ~ov_r; // RULE20 RULE22
  assign write_collision_flag_ev = wr_buf & (m_busy | (sl_on & sl_txd_r)); // RULE1 RULE2 RULE16
  // Transmit always stretches after the address; receive only with the stretch bit
  assign ckp_clr = sl_ninth & ((sl_tx_r & sl_adr_r) ? (~da_r | ~bf_r) :
                               (sen_r & bf_r & da_r & took_r)); // RULE2 RULE15

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {sl_act_r, sl_aph_r, sl_adr_r, sl_tx_r, sl_txd_r} <= 5'h00;
      {sl_ack_r, took_r, uap_r, tb_hi_r, tb_ok_r} <= 5'h00;
      bcnt_r <= 4'h0;
      sl_sr_r <= 8'h00;
    end else if (!sl_on) begin
      {sl_act_r, sl_aph_r, sl_adr_r, sl_tx_r, sl_txd_r} <= 5'h00;
      {sl_ack_r, took_r, uap_r, tb_hi_r, tb_ok_r} <= 5'h00;
      bcnt_r <= 4'h0;
    end else if (start_det) begin
      {sl_act_r, sl_aph_r} <= 2'h3;
      {sl_adr_r, sl_tx_r, sl_txd_r, sl_ack_r, took_r} <= 5'h00;
      bcnt_r <= 4'h0;
    end else if (stop_det) begin
      {sl_act_r, sl_adr_r, sl_tx_r, sl_txd_r, sl_ack_r} <= 5'h00;
      {tb_hi_r, tb_ok_r} <= 2'h0;
    end else begin
      if (sl_act_r && scl_rise) begin
        bcnt_r <= bcnt_r + 4'h1;
        if (!sl_txd_r && bcnt_r < `I2CP_BITS) begin
          sl_sr_r <= {sl_sr_r[6:0], sda_i}; // RULE21
        end
        // A master nack after a sent byte drops the slave
        if (bcnt_r == `I2CP_BITS && sl_tx_r && !sl_aph_r && sda_i) begin
          {sl_act_r, sl_adr_r, sl_tx_r} <= 3'h0;
        end
      end else if (sl_act_r && scl_fall) begin
        if (sl_txd_r && bcnt_r == `I2CP_BITS) begin
          sl_txd_r <= 1'h0;
        end else if (sl_txd_r && bcnt_r != 4'h0) begin
          sl_sr_r <= {sl_sr_r[6:0], 1'h0};
        end
        if (sl_byte) begin
          took_r <= take; // RULE18
          uap_r <= take & ten & sl_aph_r & ~hdr_rd & ~gcall; // RULE23
          sl_ack_r <= sl_ld; // RULE19
          if (take && sl_aph_r) begin
            sl_adr_r <= 1'h1;
            sl_tx_r <= sl_sr_r[0] & ~gcall;
            sl_aph_r <= ten & ~tb_hi_r & ~hdr_rd & ~gcall;
            tb_hi_r <= ten & ~tb_hi_r & ~hdr_rd & ~gcall;
            if (ten && tb_hi_r) begin
              tb_ok_r <= 1'h1;
            end
          end
        end
        if (sl_ninth) begin
          bcnt_r <= 4'h0;
          {sl_ack_r, took_r, uap_r} <= 3'h0;
          sl_txd_r <= sl_tx_r & sl_adr_r;
        end
      end
      if (wr_buf && !sl_txd_r) begin
        sl_sr_r <= req_i.wdata;
      end
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  // Control one; hardware sets win over a write in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {write_collision_flag_r, ov_r, en_r, ckp_r, mode_r} <= `I2CP_RST8;
    end else begin
      if (wr_c1) begin
        {write_collision_flag_r, ov_r, en_r, ckp_r, mode_r} <= req_i.wdata; // RULE4 RULE6
      end
      if (write_collision_flag_ev) begin
        write_collision_flag_r <= 1'h1; // RULE1 RULE2
      end
      if ((take | m_rxld) & bf_r) begin
        ov_r <= 1'h1; // RULE3
      end
      if (ckp_clr) begin
        ckp_r <= 1'h0; // RULE5
      end
    end
  end

  // Control two; requests are taken only while the master is idle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {general_call_enable_r, ackst_r, ack_data_value_r, ack_sequence_request_r, master_receive_request_r, pen_r, repeated_start_request_r, sen_r} <= `I2CP_RST8;
    end else begin
      if (wr_c2) begin
        general_call_enable_r <= req_i.wdata[`I2CP_GENERAL_CALL_ENABLE];
        ack_data_value_r <= req_i.wdata[`I2CP_ACK_DATA_VALUE];
        if (!m_busy) begin
          {ack_sequence_request_r, master_receive_request_r, pen_r, repeated_start_request_r, sen_r} <= req_i.wdata[4:0]; // RULE16
        end
      end
      if (m_done) begin
        {ack_sequence_request_r, master_receive_request_r, pen_r, repeated_start_request_r, sen_r} <= 5'h00; // RULE10 RULE12 RULE13 RULE14
      end
      if (m_ackev) begin
        ackst_r <= sda_i; // RULE9
      end
    end
  end

  // Address or reload
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_r <= `I2CP_RST8;
    end else if (wr_addr) begin
      addr_r <= req_i.wdata;
    end
  end

  // Data buffer and full flag; a load beats a read in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_r <= `I2CP_RST8;
      bf_r <= 1'h0;
    end else begin
      if (rd_buf || (sl_txd_r && sl_on && scl_fall && bcnt_r == `I2CP_BITS) ||
          (m_done && m_st_r == i2cp_pkg::M_TX)) begin
        bf_r <= 1'h0;
      end
      if (wr_buf && !write_collision_flag_ev) begin
        buf_r <= req_i.wdata;
        bf_r <= 1'h1;
      end
      if (sl_ld) begin
        buf_r <= sl_sr_r; // RULE19 RULE22
        bf_r <= 1'h1;
      end
      if (m_rxld && !bf_r) begin
        buf_r <= m_sr_r; // RULE24
        bf_r <= 1'h1;
      end
    end
  end

  // Status bits and the address update flag
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {ua_r, rw_r, da_r, s_r, p_r} <= 5'h00;
    end else begin
      if (!en_r) begin
        {s_r, p_r} <= 2'h0;
      end else if (start_det) begin
        {s_r, p_r} <= 2'h2;
      end else if (stop_det) begin
        {s_r, p_r} <= 2'h1;
      end
      if (sl_byte) begin
        da_r <= ~sl_aph_r;
      end
      if (take && sl_aph_r) begin
        rw_r <= sl_sr_r[0];
      end
      if (wr_addr) begin
        ua_r <= 1'h0; // RULE23
      end
      if (sl_ninth && uap_r) begin
        ua_r <= 1'h1; // RULE25
      end
    end
  end

  // Interrupt flag; software clears by writing zero
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_flag_o <= 1'h0;
    end else begin
      if (wr_flag) begin
        port_flag_o <= req_i.wdata[0];
      end
      if ((sl_ninth & took_r) | (sl_on & mode_r[3] & (start_det | stop_det)) | m_done) begin
        port_flag_o <= 1'h1; // RULE18 RULE22 RULE24
      end
    end
  end

  // ************************************************************
  // Read port and pins
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `I2CP_RST8;
    end else if (req_i.re) begin
      case (req_i.addr)
        `I2CP_A_CTL1: rdata_o <= {write_collision_flag_r, ov_r, en_r, ckp_r, mode_r};
        `I2CP_A_CTL2: rdata_o <= {general_call_enable_r, ackst_r, ack_data_value_r, ack_sequence_request_r, master_receive_request_r, pen_r, repeated_start_request_r, sen_r};
        `I2CP_A_STAT: rdata_o <= {2'h0, da_r, p_r, s_r, hwm ? (m_st_r == i2cp_pkg::M_TX) : rw_r, ua_r, bf_r};
        `I2CP_A_BUF: rdata_o <= buf_r;
        `I2CP_A_ADDR: rdata_o <= addr_r;
        `I2CP_A_FLAG: rdata_o <= {7'h00, port_flag_o};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Open drain: only ever pull low, release otherwise
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {scl_o, sda_o, scl_oe_n_o, sda_oe_n_o} <= 4'h3;
    end else begin
      {scl_o, sda_o} <= 2'h0; // RULE17
      scl_oe_n_o <= ~(pins_ok & (hwm ? m_scl_r : (~ckp_r | ua_r))); // RULE5 RULE23
      sda_oe_n_o <= ~(pins_ok & (hwm ? m_sda_r : (sl_ack_r | (sl_txd_r & ~sl_sr_r[7])))); // RULE19
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  mst_write_collision_flag_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE1
    m_busy && wr_buf && !m_done |=> write_collision_flag_r && $stable(buf_r)) else $error("busy write not flagged");
  slv_write_collision_flag_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE2
    sl_on && sl_txd_r && wr_buf |=> write_collision_flag_r) else $error("slave collision missed");
  rx_ovf_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
    take && bf_r |=> ov_r && !sl_ack_r) else $error("overflow missed");
  pins_off_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE26
    !(sl_on || hwm) |=> scl_oe_n_o && sda_oe_n_o) else $error("pin driven while off");
  stretch_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE5
    pins_ok && sl_on && !ckp_r |=> !scl_oe_n_o) else $error("stretch not driven");
  req_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE16
    m_busy && wr_c2 && !m_done |=> $stable({ack_sequence_request_r, master_receive_request_r, pen_r, repeated_start_request_r, sen_r}))
    else $error("request taken while busy");
  slave_ack_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE19
    sl_ld |=> sl_ack_r && bf_r && buf_r == $past(sl_sr_r)) else $error("match not acked");
  ninth_flag_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE22
    sl_ninth && took_r |=> port_flag_o) else $error("flag not set on ninth fall");
  addr_update_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE23
    wr_addr && !(sl_ninth && uap_r) |=> !ua_r) else $error("update flag not cleared");
  stop_done_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE12
    hwm && m_st_r == i2cp_pkg::M_STOP |-> ##[0:520] !pen_r) else $error("stop not finished");
  brg_rate_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE7
    hwm && tick && m_st_r != i2cp_pkg::M_IDLE && addr_r[6:0] == 7'h01 && !wr_addr && !m_done
    |=> !tick ##1 tick) else $error("baud period wrong");
endmodule

/* i2cp_map.svh */
`ifndef I2CP_MAP_SVH
`define I2CP_MAP_SVH
// Register offsets on the local port
`define I2CP_A_CTL1 3'h0
`define I2CP_A_CTL2 3'h1
`define I2CP_A_STAT 3'h2
`define I2CP_A_BUF 3'h3
`define I2CP_A_ADDR 3'h4
`define I2CP_A_FLAG 3'h5
`define I2CP_RST8 8'h00
// Control one fields
`define I2CP_WRITE_COLLISION_FLAG 7
`define I2CP_OVF 6
`define I2CP_EN 5
`define I2CP_CKP 4
// Control two fields
`define I2CP_GENERAL_CALL_ENABLE 7
`define I2CP_ACK_DATA_VALUE 5
// Mode codes
`define I2CP_M_S10I 4'hF
`define I2CP_M_S7I 4'hE
`define I2CP_M_FWM 4'hB
`define I2CP_M_HWM 4'h8
`define I2CP_M_S10 4'h7
`define I2CP_M_S7 4'h6
// Address constants
`define I2CP_TENHDR 5'h1E
`define I2CP_GCALL 8'h00
// Bit timing: four quarters per bit, eight data bits
`define I2CP_QLAST 2'h3
`define I2CP_BITS 4'h8
`endif

/* i2cp_pkg.sv */
package i2cp_pkg;
  // Master sequencer states
  typedef enum {M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK} i2cp_mst_t;
  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } i2cp_req_t;
endpackage

/* i2cp_far.sv */
`timescale 1ns/1ps
// ****************************************
// Bus peer: acks, sends bytes, watches
// ****************************************
module i2cp_far (
  input wire logic clk_i, // Sampling clock
  input wire logic scl_i, // Resolved clock line
  input wire logic sda_i, // Resolved data line
  input wire logic ack_en_i, // Ack bytes that we receive
  input wire logic send_en_i, // Act as transmitter
  input wire logic [7:0] send_byte_i, // Byte to send
  output logic sda_oe_n_o, // Low pulls data line low
  output logic [7:0] got_o, // Last byte seen on the wire
  output logic ack_seen_o // Ninth bit seen on the wire
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [3:0] cnt = 4'h0;
  initial begin
    sda_oe_n_o = 1'b1;
    got_o = 8'h00;
    ack_seen_o = 1'b1;
  end
  // Data only changes while the clock is low; released means pull-up level
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (scl_i && scl_q && sda_q && !sda_i) begin
      cnt <= 4'h0;
    end else if (scl_i && !scl_q) begin
      if (cnt < 4'h8) got_o <= {got_o[6:0], sda_i};
      else ack_seen_o <= sda_i;
      cnt <= cnt + 4'h1;
    end else if (!scl_i && scl_q && cnt == 4'h9) begin
      cnt <= 4'h0;
    end
    if (!scl_i) begin
      sda_oe_n_o <= (cnt < 4'h8) ? (!send_en_i | send_byte_i[3'h7 - cnt[2:0]]) :
                    (cnt == 4'h8) ? !(ack_en_i && !send_en_i) : 1'b1;
    end
  end
endmodule

/* i2c_master_slave_port_test.sv */
`timescale 1ns/1ps
`include "i2cp_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module i2c_master_slave_port_test;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic scl_dir_in_i = 1'b1;
  logic sda_dir_in_i = 1'b1;
  i2cp_pkg::i2cp_req_t req_i = '0;
  logic [7:0] rdata_o;
  logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, port_flag_o, far_oe_n, got_ack, ack_got;
  // Bench acting as a bus master toward the slave engine; high means released
  logic tb_scl = 1'b1;
  logic tb_sda = 1'b1;
  logic ack_en = 1'b1;
  logic send_en = 1'b0;
  logic rd_pend = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] got, b1, exp_v;
  logic [7:0] exp_q[$];
  logic [3:0] modes[6] = '{4'hF, 4'hE, 4'hB, 4'h8, 4'h7, 4'h6};
  int num_errors = 0;
  int tests_run = 0;
  time t0;
  // Open-drain wires with pull-ups
  wire scl_bus = (scl_oe_n_o ? 1'b1 : scl_o) & tb_scl;
  wire sda_bus = (sda_oe_n_o ? 1'b1 : sda_o) & far_oe_n & tb_sda;
  i2cp_port DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i), .rdata_o(rdata_o),
    .scl_i(scl_bus), .sda_i(sda_bus), .scl_dir_in_i(scl_dir_in_i), .sda_dir_in_i(sda_dir_in_i),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .port_flag_o(port_flag_o));
  i2cp_far far (.clk_i(sys_clk_i), .scl_i(scl_bus), .sda_i(sda_bus), .ack_en_i(ack_en),
    .send_en_i(send_en), .send_byte_i(send_byte), .sda_oe_n_o(far_oe_n), .got_o(got),
    .ack_seen_o(got_ack));
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // ****************************************
  // Read scoreboard: oldest note per answer
  // ****************************************
  always @(posedge sys_clk_i) begin
    // Pop once: the compare macro names its expected value twice
    if (rd_pend) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata_o, exp_v)
    end
    rd_pend <= req_i.re;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_i.addr <= a;
    req_i.wdata <= d;
    req_i.we <= 1'b1;
    @(posedge sys_clk_i);
    req_i.we <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    req_i.addr <= a;
    req_i.re <= 1'b1;
    @(posedge sys_clk_i);
    req_i.re <= 1'b0;
  endtask
  // Bounded wait for the flag, then clear it; a hang ends the run
  task automatic wait_flag;
    int n;
    for (n = 0; n < 3000 && port_flag_o !== 1'b1; n++) @(posedge sys_clk_i);
    if (n == 3000) begin
      num_errors++;
      $display("BAD %0t flag timeout", $time);
      stop_test();
    end
    wr(`I2CP_A_FLAG, `I2CP_RST8);
  endtask
  task automatic rise;
    int n, m;
    for (n = 0; n < 500 && scl_bus !== 1'b0; n++) @(posedge sys_clk_i);
    for (m = 0; m < 500 && scl_bus !== 1'b1; m++) @(posedge sys_clk_i);
    if (n == 500 || m == 500) begin
      num_errors++;
      $display("BAD %0t clock timeout", $time);
      stop_test();
    end
  endtask
  // One byte and the ack slot toward the slave, four clocks per phase
  task automatic sbyte(input logic [7:0] v);
    for (int k = 0; k < 9; k++) begin
      tb_sda <= (k < 8) ? v[7 - k] : 1'b1;
      repeat (4) @(posedge sys_clk_i);
      tb_scl <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      ack_got <= sda_bus;
      tb_scl <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
  task automatic quiet;
    repeat (40) begin
      @(posedge sys_clk_i);
      `CHK({scl_oe_n_o, sda_oe_n_o}, 2'b11)
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    b1 = 8'($urandom(32'h1CEF55B0));
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(`I2CP_A_CTL1, `I2CP_RST8);
    rd(`I2CP_A_CTL2, `I2CP_RST8);
    rd(3'h6, 8'h00);
    foreach (modes[i]) begin
      wr(`I2CP_A_CTL1, {4'h0, modes[i]});
      rd(`I2CP_A_CTL1, {4'h0, modes[i]});
    end
    done("registers");
    // Reserved mode, disabled port, pins not inputs: nothing driven
    wr(`I2CP_A_ADDR, 8'h01);
    wr(`I2CP_A_CTL2, 8'h01);
    wr(`I2CP_A_CTL1, 8'h21);
    quiet();
    wr(`I2CP_A_CTL1, 8'h08);
    quiet();
    sda_dir_in_i <= 1'b0;
    wr(`I2CP_A_CTL1, 8'h28);
    quiet();
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    sda_dir_in_i <= 1'b1;
    done("idle pins");
    // Start, then refused buffer write and stop request while busy
    wr(`I2CP_A_ADDR, 8'h01);
    wr(`I2CP_A_CTL1, 8'h28);
    wr(`I2CP_A_CTL2, 8'h01);
    wr(`I2CP_A_BUF, 8'h55);
    wr(`I2CP_A_CTL2, 8'h04);
    wait_flag();
    rd(`I2CP_A_CTL2, 8'h00);
    rd(`I2CP_A_CTL1, 8'hA8);
    wr(`I2CP_A_CTL1, 8'h28);
    done("start");
    // Byte out with ack, bit time, then byte out with no ack
    wr(`I2CP_A_BUF, b1);
    rise();
    t0 = $time;
    rise();
    `CHK(int'(($time - t0) / 50), 8)
    wait_flag();
    rd(`I2CP_A_CTL2, 8'h00);
    `CHK(got, b1)
    ack_en <= 1'b0;
    wr(`I2CP_A_BUF, ~b1);
    wait_flag();
    rd(`I2CP_A_CTL2, 8'h40);
    done("transmit");
    // Two bytes in, second lands on a full buffer
    send_en <= 1'b1;
    send_byte <= b1;
    wr(`I2CP_A_CTL2, 8'h08);
    wait_flag();
    send_byte <= ~b1;
    wr(`I2CP_A_CTL2, 8'h10);
    wait_flag();
    `CHK(got_ack, 1'b0)
    wr(`I2CP_A_CTL2, 8'h08);
    wait_flag();
    send_en <= 1'b0;
    wr(`I2CP_A_CTL2, 8'h30);
    wait_flag();
    `CHK(got_ack, 1'b1)
    rd(`I2CP_A_CTL1, 8'h68);
    rd(`I2CP_A_BUF, b1);
    rd(`I2CP_A_CTL2, 8'h60);
    done("receive");
    wr(`I2CP_A_CTL2, 8'h24);
    wait_flag();
    rd(`I2CP_A_CTL2, 8'h60);
    `CHK({scl_bus, sda_bus}, 2'b11)
    done("stop");
    // Slave 7-bit: matched address acked and buffered, then data into a full buffer
    wr(`I2CP_A_CTL1, 8'h36);
    wr(`I2CP_A_ADDR, 8'hA4);
    tb_sda <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    tb_scl <= 1'b0;
    sbyte(8'hA4);
    `CHK(ack_got, 1'b0)
    wait_flag();
    rd(`I2CP_A_STAT, 8'h09);
    sbyte(b1);
    `CHK(ack_got, 1'b1)
    wait_flag();
    rd(`I2CP_A_CTL1, 8'h76);
    rd(`I2CP_A_BUF, 8'hA4);
    tb_sda <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    tb_scl <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    tb_sda <= 1'b1;
    done("slave");
    repeat (3) @(posedge sys_clk_i);
    stop_test();
  end
endmodule
